//--- src/sbs_regs.svh
// constants of the synchronous burst memory front end: reset values, field positions, widths
// assumes inclusion by the front-end module only; definitions, no logic
`ifndef SBS_REGS_SVH
`define SBS_REGS_SVH
`define SBS_CNT_W 2
`define SBS_CNT_RST 2'h0
`define SBS_LOW_LSB 0
`define SBS_ORDER_LINEAR 1'b0
`define SBS_ORDER_RST 1'b1
`define SBS_STEP_ONE 2'h1
`endif

//--- src/sbs_pkg.sv
// types shared by the burst memory front end
// assumes the constants header is included by the module that uses these types
package sbs_pkg;
   // access state, gray coded along idle -> first -> burst
   typedef enum logic [1:0] {
      SBS_IDLE  = 2'h0, // deselected
      SBS_FIRST = 2'h1, // first clock after a selecting load out of deselect
      SBS_BURST = 2'h3  // selected, later clocks
   } sbs_state_e;
endpackage : sbs_pkg

//--- src/sbs_front_end.sv
// synchronous control front end of a flow-through burst static memory
// assumes the array sits outside: async read at mem_addr, write one clock after the request edge
`timescale 1ns/1ps
`include "sbs_regs.svh"
module sbs_front_end #(
   parameter int ADDR_W = 19, // total word address width, low two bits included
   parameter int LANES = 4,   // byte lanes
   parameter int LANE_W = 8   // data bits per lane, parity pin extra
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [ADDR_W-3:0] addr_upper,
   input wire logic addr_bit_zero,
   input wire logic addr_bit_one,
   input wire logic cpu_addr_strobe_n,
   input wire logic ctrl_addr_strobe_n,
   input wire logic burst_step_n,
   input wire logic select_primary_n,
   input wire logic select_expand_high,
   input wire logic select_expand_low_n,
   input wire logic lane_write_sel_a_n,
   input wire logic lane_write_sel_b_n,
   input wire logic lane_write_sel_c_n,
   input wire logic lane_write_sel_d_n,
   input wire logic lane_write_qualify_n,
   input wire logic all_lanes_write_n,
   input wire logic out_enable_n,
   input wire logic burst_order,
   input wire logic [LANES*LANE_W-1:0] dq_in,
   output logic [LANES*LANE_W-1:0] dq_out,
   output logic [LANES*LANE_W-1:0] dq_oe,
   input wire logic [LANES-1:0] parity_pins_in,
   output logic [LANES-1:0] parity_pins_out,
   output logic [LANES-1:0] parity_pins_oe,
   output logic [ADDR_W-1:0] mem_addr,
   input wire logic [LANES*(LANE_W+1)-1:0] mem_rdata,
   output logic [ADDR_W-1:0] mem_waddr,
   output logic [LANES-1:0] mem_wen,
   output logic [LANES*(LANE_W+1)-1:0] mem_wdata
);
   localparam int WORD_W = LANES * (LANE_W + 1); // lane data plus parity

   // whole module state in one packed record
   typedef struct packed {
      sbs_pkg::sbs_state_e st;          // selection / first-clock tracking
      logic [ADDR_W-3:0] addr_hi;       // captured upper address
      logic [`SBS_CNT_W-1:0] base;      // captured low bits
      logic [`SBS_CNT_W-1:0] step;      // beats advanced since load
      logic order;                      // burst order taken at load
      logic [LANES-1:0] wen;            // lane writes for the array
      logic [ADDR_W-1:0] waddr;         // write address for the array
      logic [WORD_W-1:0] wdata;         // write word for the array
      logic [WORD_W-1:0] rd;            // read word on the pins
   } sbs_state_s;

   sbs_state_s s_q; // registered state
   sbs_state_s s_d; // next state

   logic [LANES-1:0] lane_sel_n; // lane selects gathered, lane a at bit 0
   logic cpu_take;               // processor strobe accepted
   logic load;                   // a new external address is loaded
   logic chip_sel;               // all three selects active
   logic [`SBS_CNT_W-1:0] low_q; // low address bits of current beat
   logic [`SBS_CNT_W-1:0] low_d; // low address bits of next beat
   logic [LANES-1:0] wr_lanes;   // lanes written at this edge
   logic [WORD_W-1:0] pin_word;  // data pins packed lane by lane
   logic drive;                  // pins may drive

   assign lane_sel_n = {lane_write_sel_d_n, lane_write_sel_c_n, lane_write_sel_b_n, lane_write_sel_a_n};

   // processor strobe is blocked while the primary select is high
   assign cpu_take = !cpu_addr_strobe_n && !select_primary_n;
   // controller strobe only counts when the processor strobe is not low
   assign load = cpu_take || (!ctrl_addr_strobe_n && cpu_addr_strobe_n);
   assign chip_sel = !select_primary_n && select_expand_high && !select_expand_low_n;

   // wrapping order: add for linear, xor for interleaved; upper bits never touched
   function automatic logic [`SBS_CNT_W-1:0] beat_low(input logic ord, input logic [`SBS_CNT_W-1:0] b,
                                                      input logic [`SBS_CNT_W-1:0] k);
      logic [`SBS_CNT_W-1:0] r;
      r = (ord == `SBS_ORDER_LINEAR) ? `SBS_CNT_W'(b + k) : (b ^ k);
      return r;
   endfunction : beat_low

   assign low_q = beat_low(s_q.order, s_q.base, s_q.step);

   // lane selection for this edge; global write overrides lane selects
   always_comb begin
      if (!all_lanes_write_n) begin
         wr_lanes = {LANES{1'b1}};
      end else if (!lane_write_qualify_n) begin
         wr_lanes = ~lane_sel_n;
      end else begin
         wr_lanes = '0;
      end
   end

   // pack pins per lane: data bits then parity bit
   genvar gl;
   generate
      for (gl = 0; gl < LANES; gl++) begin : g_lane
         assign pin_word[gl*(LANE_W+1) +: LANE_W] = dq_in[gl*LANE_W +: LANE_W];
         assign pin_word[gl*(LANE_W+1) + LANE_W] = parity_pins_in[gl];
         // read word from flip-flops, enables shared per lane
         assign dq_out[gl*LANE_W +: LANE_W] = s_q.rd[gl*(LANE_W+1) +: LANE_W];
         assign parity_pins_out[gl] = s_q.rd[gl*(LANE_W+1) + LANE_W];
         assign dq_oe[gl*LANE_W +: LANE_W] = {LANE_W{drive}};
         assign parity_pins_oe[gl] = drive;
      end
   endgenerate

   // next-state logic; continuation edges sample the write and step inputs, selecting controller loads the write inputs, selects and address only on a load
   always_comb begin
      s_d = s_q;
      s_d.wen = '0; // write strobes last one clock
      low_d = low_q;
      if (load) begin
         // selects looked at only here, never during continuation
         if (chip_sel) begin
            s_d.addr_hi = addr_upper;
            s_d.base = {addr_bit_one, addr_bit_zero};
            s_d.step = `SBS_CNT_RST;
            s_d.order = burst_order;
            s_d.st = (s_q.st == sbs_pkg::SBS_IDLE) ? sbs_pkg::SBS_FIRST : sbs_pkg::SBS_BURST;
            low_d = {addr_bit_one, addr_bit_zero};
            // processor-strobe loads always start as reads
            if (!cpu_take) begin
               s_d.wen = wr_lanes;
            end
         end else begin
            s_d.st = sbs_pkg::SBS_IDLE; // deselect
         end
      end else if (s_q.st != sbs_pkg::SBS_IDLE) begin
         s_d.st = sbs_pkg::SBS_BURST; // first clock over
         s_d.wen = wr_lanes;
         // advance only on step low; wraps inside the group of four
         if (!burst_step_n) begin
            s_d.step = `SBS_CNT_W'(s_q.step + `SBS_STEP_ONE);
            low_d = beat_low(s_q.order, s_q.base, s_d.step);
         end
      end
      // write goes to the beat address that was just in force at this edge
      s_d.waddr = {s_d.addr_hi, load ? low_d : low_q};
      s_d.wdata = pin_word;
      s_d.rd = mem_rdata; // flow-through: array read at next address
   end

   assign mem_addr = {s_d.addr_hi, low_d};
   assign mem_waddr = s_q.waddr;
   assign mem_wen = s_q.wen;
   assign mem_wdata = s_q.wdata;

   // output enable is asynchronous; writes, deselect and the first clock force high impedance
   // write intent is taken from the pins so the bus is freed in the data phase itself
   assign drive = !out_enable_n
                  && (s_q.st == sbs_pkg::SBS_BURST)
                  && !(|wr_lanes);

   // single rising-edge register for all state; sync reset leaves device deselected
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_q <= '0;
         s_q.st <= sbs_pkg::SBS_IDLE;
         s_q.order <= `SBS_ORDER_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // checks on the front end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_sel_load;
      load && chip_sel;
   endsequence
   sequence s_hold_beat;
      !load && burst_step_n && (s_q.st != sbs_pkg::SBS_IDLE);
   endsequence

   property p_addr_cap;
      s_sel_load |=> (s_q.addr_hi == $past(addr_upper));
   endproperty
   a_addr_cap: assert property (p_addr_cap) else $error("address not captured");

   property p_cnt_load;
      s_sel_load |=> (s_q.step == `SBS_CNT_RST) && (s_q.base == $past({addr_bit_one, addr_bit_zero}));
   endproperty
   a_cnt_load: assert property (p_cnt_load) else $error("counter not loaded");

   property p_lane_wr;
      (s_q.st != sbs_pkg::SBS_IDLE) && !load && all_lanes_write_n && !lane_write_qualify_n
         |=> (mem_wen == ~$past(lane_sel_n));
   endproperty
   a_lane_wr: assert property (p_lane_wr) else $error("lane write mismatch");

   property p_all_wr;
      (s_q.st != sbs_pkg::SBS_IDLE) && !load && !all_lanes_write_n |=> (&mem_wen);
   endproperty
   a_all_wr: assert property (p_all_wr) else $error("global write lost lanes");

   // beat address must not move on a continuation edge without step
   property p_hold;
      s_hold_beat |=> $stable(low_q);
   endproperty
   a_hold: assert property (p_hold) else $error("counter moved without step");

   property p_step;
      !load && !burst_step_n && (s_q.st != sbs_pkg::SBS_IDLE)
         |=> (s_q.step == 2'($past(s_q.step) + 2'h1)) && $stable(s_q.addr_hi);
   endproperty
   a_step: assert property (p_step) else $error("counter did not advance");

   // a blocked strobe loads nothing; a continuation write may still go on, so wen is not judged here
   property p_cpu_block;
      !cpu_addr_strobe_n && select_primary_n |=> $stable(s_q.addr_hi) && $stable(s_q.base);
   endproperty
   a_cpu_block: assert property (p_cpu_block) else $error("blocked strobe acted");

   property p_desel;
      load && (!select_expand_high || select_expand_low_n) |=> (s_q.st == sbs_pkg::SBS_IDLE);
   endproperty
   a_desel: assert property (p_desel) else $error("selected without all selects");

   property p_no_resample;
      !load |=> ((s_q.st == sbs_pkg::SBS_IDLE) == ($past(s_q.st) == sbs_pkg::SBS_IDLE));
   endproperty
   a_no_resample: assert property (p_no_resample) else $error("selects resampled");

   // selecting load out of deselect: the clock after it keeps every pin undriven
   property p_first_off;
      load && chip_sel && (s_q.st == sbs_pkg::SBS_IDLE) |=> (dq_oe == '0) && (parity_pins_oe == '0);
   endproperty
   a_first_off: assert property (p_first_off) else $error("pins driven on first clock");

   // output enable high always frees the pins
   property p_oe_high;
      out_enable_n |-> (dq_oe == '0) && (parity_pins_oe == '0);
   endproperty
   a_oe_high: assert property (p_oe_high) else $error("pins driven with enable high");

   property p_cpu_wins;
      !cpu_addr_strobe_n && !ctrl_addr_strobe_n && chip_sel |=> (mem_wen == '0);
   endproperty
   a_cpu_wins: assert property (p_cpu_wins) else $error("controller strobe acted");

   property p_wr_off;
      (|wr_lanes) |-> (dq_oe == '0) && (parity_pins_oe == '0);
   endproperty
   a_wr_off: assert property (p_wr_off) else $error("pins driven during write");

endmodule : sbs_front_end

//--- verif/sbs_array_model.sv
// behavioural array behind the front end: async read, lane writes on the clock
// assumes a 4-bit word index is enough for the bench's traffic
`timescale 1ns/1ps
module sbs_array_model (
   input wire logic clk,
   input wire logic [18:0] mem_addr,
   output logic [35:0] mem_rdata,
   input wire logic [18:0] mem_waddr,
   input wire logic [3:0] mem_wen,
   input wire logic [35:0] mem_wdata
);
   logic [35:0] mem [16]; // small window, upper address bits aliased
   // unwritten words carry their own index in each lane, so a wrong beat shows
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = {4{5'h00, 4'(i)}};
   end
   assign mem_rdata = mem[mem_addr[3:0]]; // async read
   // lane writes land on the edge where the pulse is high
   always @(posedge clk) begin
      for (int l = 0; l < 4; l++) if (mem_wen[l]) mem[mem_waddr[3:0]][9*l+:9] <= mem_wdata[9*l+:9];
   end
endmodule : sbs_array_model

//--- verif/tb.sv
// self-checking bench of the burst memory front end; the bench plays the bus controller
// assumes the array model above and inputs driven on the falling edge
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0, rstn = 1'b0, addr_bit_zero = 1'b0, addr_bit_one = 1'b0, burst_order = 1'b0;
   logic cpu_addr_strobe_n = 1'b1, ctrl_addr_strobe_n = 1'b1, burst_step_n = 1'b1, out_enable_n = 1'b0;
   logic select_primary_n = 1'b0, select_expand_high = 1'b1, select_expand_low_n = 1'b0;
   logic lane_write_qualify_n = 1'b1, all_lanes_write_n = 1'b1;
   logic [3:0] lsel_n = 4'hF, parity_pins_in = 4'h0, parity_pins_out, parity_pins_oe, mem_wen;
   logic [16:0] addr_upper = 17'h00002; // word index 8..11 in the model
   logic [31:0] dq_in = 32'h0, dq_out, dq_oe;
   logic [18:0] mem_addr, mem_waddr;
   logic [35:0] mem_rdata, mem_wdata;
   int n_fail = 0, tests_run = 0;
   // free-running 20 MHz clock
   initial begin
      forever #25 clk = ~clk;
   end
   sbs_front_end sbs_front_end_i (.clk, .rstn, .addr_upper, .addr_bit_zero, .addr_bit_one, .cpu_addr_strobe_n,
      .ctrl_addr_strobe_n, .burst_step_n, .select_primary_n, .select_expand_high, .select_expand_low_n,
      .lane_write_sel_a_n(lsel_n[0]), .lane_write_sel_b_n(lsel_n[1]), .lane_write_sel_c_n(lsel_n[2]),
      .lane_write_sel_d_n(lsel_n[3]), .lane_write_qualify_n, .all_lanes_write_n, .out_enable_n, .burst_order,
      .dq_in, .dq_out, .dq_oe, .parity_pins_in, .parity_pins_out, .parity_pins_oe, .mem_addr, .mem_rdata,
      .mem_waddr, .mem_wen, .mem_wdata);
   sbs_array_model sbs_array_model_i (.clk, .mem_addr, .mem_rdata, .mem_waddr, .mem_wen, .mem_wdata);
   // one compare for every value kind, four-state exact
   task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // step to the next drive point, past one rising edge
   task automatic tick();
      @(negedge clk);
   endtask : tick
   // deselect, then a burst read with a strobe collision and a mid-burst ignored strobe
   task automatic t_read(input logic ord, input logic [1:0] base);
      logic [1:0] k;
      ctrl_addr_strobe_n = 1'b0;
      select_expand_high = 1'b0; // deselecting load
      tick();
      select_expand_high = 1'b1;
      burst_order = ord;
      {addr_bit_one, addr_bit_zero} = base;
      cpu_addr_strobe_n = 1'b0;
      all_lanes_write_n = 1'b0; // processor strobe wins, so a read
      tick();
      {cpu_addr_strobe_n, ctrl_addr_strobe_n, all_lanes_write_n} = 3'h7;
      chk("wen on both strobes", 36'h0, 36'(mem_wen));
      chk("oe first clock", 36'h0, 36'(dq_oe));
      chk("parity oe first clock", 36'h0, 36'(parity_pins_oe));
      chk("first beat", 36'({4{6'h02, base}}), 36'(dq_out));
      tick();
      chk("held beat", 36'({4{6'h02, base}}), 36'(dq_out));
      for (int j = 1; j <= 4; j++) begin
         k = ord ? base ^ 2'(j) : base + 2'(j); // wraps inside four
         burst_step_n = 1'b0;
         // plain steps keep the processor strobe high; beat two tries a blocked strobe
         {select_primary_n, cpu_addr_strobe_n, select_expand_high} = (j == 2) ? 3'h4 : 3'h3;
         tick();
         chk("beat", 36'({4{6'h02, k}}), 36'(dq_out));
         chk("oe in burst", 36'hFFFFFFFF, 36'(dq_oe));
         chk("parity oe in burst", 36'hF, 36'(parity_pins_oe));
      end
      {select_primary_n, cpu_addr_strobe_n, select_expand_high, burst_step_n} = 4'h7;
      out_enable_n = 1'b1;
      #1 chk("oe released", 36'h0, 36'(dq_oe));
      chk("parity oe released", 36'h0, 36'(parity_pins_oe));
      // restore the enable on the next drive point, not off the falling edge
      tick();
      out_enable_n = 1'b0;
      $display("read test done order %0d", ord);
   endtask : t_read
   // global write on a load, then lane writes needing the qualifier
   task automatic t_write();
      logic [35:0] w;
      dq_in = 32'hC3A5_5A3C;
      parity_pins_in = 4'h9;
      addr_upper = 17'h00001;
      {addr_bit_one, addr_bit_zero} = 2'h1;
      for (int l = 0; l < 4; l++) w[9*l+:9] = {parity_pins_in[l], dq_in[8*l+:8]};
      ctrl_addr_strobe_n = 1'b0;
      all_lanes_write_n = 1'b0;
      tick();
      {ctrl_addr_strobe_n, all_lanes_write_n} = 2'h3;
      chk("global wen", 36'hF, 36'(mem_wen));
      chk("wdata", w, mem_wdata);
      chk("waddr", 36'h5, 36'(mem_waddr));
      lsel_n = 4'hD; // lane b only, qualifier still high
      tick();
      lane_write_qualify_n = 1'b0;
      #1 chk("oe in write", 36'h0, 36'(dq_oe));
      chk("unqualified wen", 36'h0, 36'(mem_wen));
      tick();
      {lsel_n, lane_write_qualify_n} = 5'h1F;
      chk("lane wen", 36'h2, 36'(mem_wen));
      $display("write test done");
   endtask : t_write
   // deselected and ignored loads drop writes and keep pins quiet, then read back
   task automatic t_desel();
      {ctrl_addr_strobe_n, select_expand_low_n, all_lanes_write_n} = 3'h2;
      tick();
      // the deselecting load raises no write pulse at its edge
      chk("deselected wen", 36'h0, 36'(mem_wen));
      {ctrl_addr_strobe_n, select_expand_low_n, cpu_addr_strobe_n, select_primary_n} = 4'h9;
      tick();
      chk("ignored strobe wen", 36'h0, 36'(mem_wen));
      {cpu_addr_strobe_n, select_primary_n, all_lanes_write_n} = 3'h7;
      tick();
      chk("deselected oe", 36'h0, 36'(dq_oe));
      cpu_addr_strobe_n = 1'b0;
      tick();
      cpu_addr_strobe_n = 1'b1;
      chk("read back", 36'(dq_in), 36'(dq_out));
      chk("read back parity", 36'(parity_pins_in), 36'(parity_pins_out));
      $display("deselect test done");
   endtask : t_desel
   // verdict and end of run
   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results
   // main sequence
   initial begin
      repeat (16) @(negedge clk);
      chk("reset oe", 36'h0, 36'(dq_oe));
      chk("reset wen", 36'h0, 36'(mem_wen));
      rstn = 1'b1;
      t_read(1'b0, 2'h2);
      t_read(1'b1, 2'h1);
      t_write();
      t_desel();
      results();
   end
   // watchdog, far beyond the ~40 cycles the tests need
   initial begin
      repeat (1000) @(posedge clk);
      n_fail++;
      $display("[ERR] watchdog expected end seen hang");
      results();
   end
endmodule : tb
